//--- logic/ubg_baud_gen.sv
`timescale 1ns/1ps
module ubg_baud_gen (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire ubg_pkg::ubg_cfg_t cfg,
  input  wire logic            frame_start,
  input  wire logic            frame_active,
  output logic                 bit_tick_q,
  output logic                 sample_q
);
  import ubg_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic             extra_q;
  logic [ACC_W-1:0] acc_q;
  logic [DIV_W-1:0] half;
  logic [DIV_W-1:0] last;
  logic             bit_end;
  logic             new_bit;
  logic [ACC_W-1:0] acc_base;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] low_sum;
  logic [DIV_W-1:0] s0;
  logic [DIV_W-1:0] s1;
  logic [DIV_W-1:0] s2;

  assign half     = cfg.divisor >> 1;
  // Lengthened bit lasts divisor + 1 clocks
  assign last     = cfg.divisor - DIV_W'(!extra_q);  // see R1
  assign bit_end  = cnt_q >= last;
  assign new_bit  = frame_start | (bit_end & frame_active);
  assign acc_base = frame_start ? '0 : acc_q;  // see R6
  assign acc_sum  = acc_base + ACC_W'(cfg.modulation);  // see R5
  assign low_sum  = ACC_W'(acc_base[MOD_W-1:0]) + ACC_W'(cfg.modulation);

  // Free-running; a start bit realigns it to the frame
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (frame_start || bit_end) begin  // see R15
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q   <= '0;
      extra_q <= 1'b0;
    end else if (new_bit) begin
      acc_q   <= acc_sum;  // see R6
      extra_q <= low_sum[MOD_W];  // see R5
    end else if (bit_end) begin
      extra_q <= 1'b0;
    end
  end

  assign s0 = cfg.range_sel ? half - DIV_W'(1) : half;  // see R7
  assign s1 = cfg.range_sel ? half : half + DIV_W'(1);
  assign s2 = half + SAMPLE_LATE;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_tick_q <= 1'b0;
      sample_q   <= 1'b0;
    end else begin
      bit_tick_q <= bit_end;
      sample_q   <= frame_active &&
                    (cnt_q == s0 || cnt_q == s1 || cnt_q == s2);  // see R7
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_acc_restart: assert property (  // see R6
    frame_start |=> acc_q == ACC_W'($past(cfg.modulation)))
    else $error("accumulator did not restart at start bit");

  a_extra_carry: assert property (  // see R5
    new_bit && !frame_start |=> extra_q ==
      (int'($past(acc_q[MOD_W-1:0])) + int'($past(cfg.modulation)) > 7))
    else $error("extra clock does not match accumulator carry");

  a_sample_span: assert property (  // see R7
    sample_q |-> $past(cnt_q) + DIV_W'(1) >= $past(half) &&
                 $past(cnt_q) <= $past(half) + SAMPLE_LATE)
    else $error("sample strobe outside the mid-bit window");

  c_extra_bit: cover property (new_bit && low_sum[MOD_W]);
endmodule

//--- logic/ubg_pkg.sv
package ubg_pkg;

  localparam int DIV_W   = 16;
  localparam int MOD_W   = 3;
  localparam int ACC_W   = 4;
  localparam int DATA_W  = 8;
  localparam int DEPTH   = 4;
  localparam int PTR_W   = 2;
  localparam int CNT_W   = 3;
  localparam int ADDR_W  = 8;
  localparam int FMC_W   = 6;
  localparam int CTRL_W  = 2;

  // Byte addresses of the register words
  localparam logic [ADDR_W-1:0] OFF_DIV_LOW  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FMC      = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_DATA     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STAT     = 8'h18;

  // Field positions
  localparam int FMC_TRIG_LSB  = 0;
  localparam int FMC_RANGE_BIT = 2;
  localparam int FMC_MOD_LSB   = 3;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_RIE_BIT  = 1;
  localparam int STAT_AVL_BIT  = 0;
  localparam int STAT_OVR_BIT  = 1;

  // Reset values, full FIFO count and late sample offset
  localparam logic [DATA_W-1:0] DIV_BYTE_RST = 8'h00;
  localparam logic [FMC_W-1:0]  FMC_RST      = 6'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 2'h0;
  localparam logic [CNT_W-1:0]  FIFO_FULL    = 3'h4;
  localparam logic [DIV_W-1:0]  SAMPLE_LATE  = 16'h0002;

  typedef enum logic [1:0] {
    TRIG_FOUR  = 2'b00,
    TRIG_ONE   = 2'b01,
    TRIG_TWO   = 2'b10,
    TRIG_THREE = 2'b11
  } ubg_trig_t;

  typedef struct packed {
    logic [DIV_W-1:0] divisor;
    logic [MOD_W-1:0] modulation;
    logic             range_sel;
  } ubg_cfg_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ubg_apb_req_t;

  // Receive-available level reached for the chosen trigger code
  function automatic logic ubg_trig_met(input logic [CNT_W-1:0] cnt,
                                        input ubg_trig_t code);
    logic [CNT_W-1:0] lvl;
    lvl = 3'h0;
    unique case (code)
      TRIG_FOUR:  lvl = 3'h4;
      TRIG_ONE:   lvl = 3'h1;
      TRIG_TWO:   lvl = 3'h2;
      TRIG_THREE: lvl = 3'h3;
    endcase
    return cnt >= lvl;
  endfunction

endpackage

//--- logic/ubg_rx_fifo.sv
`timescale 1ns/1ps
module ubg_rx_fifo (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic                       flush,
  input  wire logic                       push,
  input  wire logic [ubg_pkg::DATA_W-1:0] push_data,
  input  wire logic                       pop,
  output logic      [ubg_pkg::DATA_W-1:0] head,
  output logic      [ubg_pkg::CNT_W-1:0]  count_q,
  output logic                            overrun_q
);
  import ubg_pkg::*;

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0]  wr_q;
  logic [PTR_W-1:0]  rd_q;
  logic [DATA_W-1:0] hold_q;
  logic              hold_v_q;
  logic              do_pop;
  logic              from_hold;
  logic              from_in;
  logic              write;

  assign head      = mem_q[rd_q];
  assign do_pop    = pop && count_q != '0;
  // Shift register refills the FIFO as soon as a slot opens
  assign from_hold = do_pop && hold_v_q;  // see R13
  assign from_in   = push && !hold_v_q && (count_q < FIFO_FULL || do_pop);
  assign write     = from_hold || from_in;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (write) begin
      mem_q[wr_q] <= from_hold ? hold_q : push_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin  // see R11
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else if (flush) begin  // see R20
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      wr_q    <= wr_q + PTR_W'(write);
      rd_q    <= rd_q + PTR_W'(do_pop);
      count_q <= count_q + CNT_W'(write) - CNT_W'(do_pop);  // see R12
    end
  end

  // Fifth byte waits here; a sixth overwrites it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q    <= '0;
      hold_v_q  <= 1'b0;
      overrun_q <= 1'b0;
    end else if (flush) begin
      hold_v_q  <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= push && hold_v_q && !from_hold;  // see R13
      if (push && !from_in) begin
        hold_q   <= push_data;
        hold_v_q <= 1'b1;
      end else if (from_hold) begin
        hold_v_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_count_cap: assert property (count_q <= FIFO_FULL)  // see R13
    else $error("byte count above four");

  a_count_step: assert property (  // see R12
    !flush && push && !do_pop && count_q < FIFO_FULL && !hold_v_q
      |=> count_q == $past(count_q) + CNT_W'(1))
    else $error("count did not rise on a stored byte");

  a_count_pop: assert property (  // see R12
    !flush && do_pop && !push && !hold_v_q
      |=> count_q == $past(count_q) - CNT_W'(1))
    else $error("count did not fall on a read");

  c_hold_used: cover property (push && hold_v_q);
endmodule

//--- logic/ubg_uart_baud_rx.sv
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
// How it works
// R1: Bit time is uart_clock over divisor plus modulation eighths.
// R2: Software keeps divisor at least 16, or 8 with range select.
// R3: Software writes divisor low byte before the high byte.
// R4: Software leaves low byte and range select alone mid-frame.
// R5: Modulation added per bit; carry out of bit 2 adds one clock.
// R6: Accumulator restarts at each start bit, advances every frame bit.
// R7: Range select picks the three sampling points around mid-bit.
// R8: Receive-available flag rises at the selected FIFO fill level.
// R9: Available flag with receive interrupt enable raises the interrupt.
// R10: Software should pick a two-byte trigger to avoid overrun.
// R11: Receive FIFO is empty after reset.
// R12: Unread count rises on a stored byte, falls on a read.
// R13: Four-byte FIFO; fifth byte waits, sixth replaces it, count stays 4.
// R14: Unread count clears on reset and when the module is disabled.
// R15: Bit timing comes from a free-running 16-bit timer.
// R16: Two stop bits are recommended for receiver resynchronisation.
// R17: Software loads truncated ratio and rounded fraction times eight.
// R18: Unimplemented upper control and count bits read as zero.
// R19: With enable set, overrun or available flag raises the interrupt.
// R20: Disabling empties buffers, clears count and flags, keeps settings.
module ubg_uart_baud_rx (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire ubg_pkg::ubg_apb_req_t      apb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       frame_start,
  input  wire logic                       frame_active,
  input  wire logic                       rx_byte_valid,
  input  wire logic [ubg_pkg::DATA_W-1:0] rx_byte,
  output logic                            bit_tick,
  output logic                            sample_strobe,
  output logic                            uart_irq
);
  import ubg_pkg::*;

  logic [DATA_W-1:0] div_low_q;
  logic [DIV_W-1:0]  divisor_q;
  logic [FMC_W-1:0]  fmc_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic              avail_q;
  logic              ovr_q;
  logic              irq_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              pop_ok_q;
  logic              setup;
  logic              access;
  logic              wr;
  logic              rd;
  logic              module_enable;
  logic              rx_interrupt_enable;
  ubg_trig_t         rx_trigger_level;
  ubg_cfg_t          cfg;
  logic [DATA_W-1:0] fifo_head;
  logic [CNT_W-1:0]  rx_fifo_byte_count;
  logic              fifo_overrun;
  logic              fifo_pop;
  logic              ovr_clear;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFF_DIV_LOW || a == OFF_DIV_HIGH || a == OFF_FMC ||
           a == OFF_COUNT || a == OFF_DATA || a == OFF_CTRL ||
           a == OFF_STAT;
  endfunction

  assign setup  = apb.psel && !apb.penable;
  assign access = apb.psel && apb.penable && pready_q;
  assign wr     = access && apb.pwrite;
  assign rd     = access && !apb.pwrite;

  assign module_enable       = ctrl_q[CTRL_EN_BIT];
  assign rx_interrupt_enable = ctrl_q[CTRL_RIE_BIT];
  assign rx_trigger_level    = ubg_trig_t'(fmc_q[FMC_TRIG_LSB +: 2]);

  assign cfg.divisor    = divisor_q;
  assign cfg.modulation = fmc_q[FMC_MOD_LSB +: MOD_W];
  assign cfg.range_sel  = fmc_q[FMC_RANGE_BIT];

  // Zero-wait slave: pready answers in the first access cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped(apb.paddr);
    end
  end

  // Read data captured in setup; pop allowed only if the head was valid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= '0;
      pop_ok_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= '0;
      pop_ok_q <= !apb.pwrite && apb.paddr == OFF_DATA &&
                  rx_fifo_byte_count != '0;
      if (!apb.pwrite) begin
        unique case (apb.paddr)
          OFF_DIV_LOW:  prdata_q[DATA_W-1:0] <= div_low_q;
          OFF_DIV_HIGH: prdata_q[DATA_W-1:0] <= divisor_q[DIV_W-1:DATA_W];
          OFF_FMC:      prdata_q[FMC_W-1:0]  <= fmc_q;  // see R18
          OFF_COUNT:    prdata_q[CNT_W-1:0]  <= rx_fifo_byte_count;  // see R18
          OFF_DATA:     prdata_q[DATA_W-1:0] <=
                          rx_fifo_byte_count != '0 ? fifo_head : '0;
          OFF_CTRL:     prdata_q[CTRL_W-1:0] <= ctrl_q;
          OFF_STAT:     begin
            prdata_q[STAT_AVL_BIT] <= avail_q;
            prdata_q[STAT_OVR_BIT] <= ovr_q;
          end
          default:      prdata_q <= '0;
        endcase
      end
    end
  end

  // Low byte is staged; the high-byte write commits the whole divisor
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_low_q <= DIV_BYTE_RST;
      divisor_q <= {DIV_BYTE_RST, DIV_BYTE_RST};
    end else if (wr && apb.paddr == OFF_DIV_LOW) begin
      div_low_q <= apb.pwdata[DATA_W-1:0];
    end else if (wr && apb.paddr == OFF_DIV_HIGH) begin
      divisor_q <= {apb.pwdata[DATA_W-1:0], div_low_q};  // see R1, R3
    end
  end

  // Settings survive a module disable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fmc_q <= FMC_RST;
    end else if (wr && apb.paddr == OFF_FMC) begin
      fmc_q <= apb.pwdata[FMC_W-1:0];  // see R20
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr && apb.paddr == OFF_CTRL) begin
      ctrl_q <= apb.pwdata[CTRL_W-1:0];
    end
  end

  assign fifo_pop  = rd && apb.paddr == OFF_DATA && pop_ok_q;
  assign ovr_clear = wr && apb.paddr == OFF_STAT &&
                     apb.pwdata[STAT_OVR_BIT];

  ubg_rx_fifo u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .flush     (!module_enable),  // see R14, R20
    .push      (rx_byte_valid && module_enable),
    .push_data (rx_byte),
    .pop       (fifo_pop),
    .head      (fifo_head),
    .count_q   (rx_fifo_byte_count),
    .overrun_q (fifo_overrun)
  );

  ubg_baud_gen u_baud (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .cfg          (cfg),
    .frame_start  (frame_start),
    .frame_active (frame_active),
    .bit_tick_q   (bit_tick),
    .sample_q     (sample_strobe)
  );

  // Available is a level: it drops once reads bring the count below
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avail_q <= 1'b0;
    end else begin
      avail_q <= module_enable &&
                 ubg_trig_met(rx_fifo_byte_count, rx_trigger_level);  // see R8
    end
  end

  // Overrun set beats a simultaneous software clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_q <= 1'b0;
    end else if (!module_enable) begin
      ovr_q <= 1'b0;  // see R20
    end else if (fifo_overrun) begin
      ovr_q <= 1'b1;
    end else if (ovr_clear) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rx_interrupt_enable && (avail_q || ovr_q);  // see R9, R19
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign uart_irq = irq_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_irq_gated: assert property (  // see R19
    !rx_interrupt_enable |=> !uart_irq)
    else $error("interrupt raised with receive interrupt disabled");

  a_irq_on_avail: assert property (  // see R9
    rx_interrupt_enable && avail_q |=> uart_irq)
    else $error("available flag did not raise the interrupt");

  a_avail_level: assert property (  // see R8
    module_enable && rx_fifo_byte_count == FIFO_FULL |=> avail_q)
    else $error("full FIFO did not raise the available flag");

  a_avail_one: assert property (  // see R8
    module_enable && rx_trigger_level == TRIG_ONE &&
    rx_fifo_byte_count == '0 |=> !avail_q)
    else $error("available flag raised with an empty FIFO");

  a_disable_clear: assert property (  // see R14
    !module_enable |=> rx_fifo_byte_count == '0 ##0 !ovr_q)
    else $error("disable did not clear count and overrun");

  a_divisor_commit: assert property (  // see R3
    wr && apb.paddr == OFF_DIV_HIGH |=>
      divisor_q == {$past(apb.pwdata[DATA_W-1:0]), $past(div_low_q)})
    else $error("high byte write did not commit the divisor");

  a_count_upper: assert property (  // see R18
    setup && !apb.pwrite && (apb.paddr == OFF_COUNT ||
      apb.paddr == OFF_FMC) |=> prdata[31:FMC_W] == '0)
    else $error("unimplemented register bits read as one");

  a_settings_kept: assert property (  // see R20
    $fell(module_enable) |=> $stable(fmc_q) && $stable(divisor_q))
    else $error("disable disturbed the baud and trigger settings");

  a_ovr_set_wins: assert property (
    module_enable && fifo_overrun && ovr_clear |=> ovr_q)
    else $error("overrun lost against a clear");

  a_pready_pulse: assert property (
    setup |=> pready)
    else $error("pready missing after setup");

  a_pready_once: assert property (
    pready |=> !pready)
    else $error("pready held over one cycle");

  a_err_unmapped: assert property (
    setup && !mapped(apb.paddr) |=> pslverr)
    else $error("unmapped address gave no error");

  a_err_mapped: assert property (
    setup && mapped(apb.paddr) |=> !pslverr)
    else $error("mapped address gave an error");

  a_stat_read: assert property (  // see R8
    setup && !apb.pwrite && apb.paddr == OFF_STAT |=>
      prdata[STAT_AVL_BIT] == $past(avail_q))
    else $error("status read lost the available flag");

  a_count_read: assert property (  // see R18
    setup && !apb.pwrite && apb.paddr == OFF_COUNT |=>
      prdata == 32'($past(rx_fifo_byte_count)))
    else $error("count read not zero-extended");

  a_data_empty: assert property (
    setup && !apb.pwrite && apb.paddr == OFF_DATA &&
    rx_fifo_byte_count == '0 |=> prdata == '0)
    else $error("empty FIFO read returned data");

  a_ovr_sticky: assert property (  // see R19
    module_enable && ovr_q && !ovr_clear |=> ovr_q)
    else $error("overrun flag dropped by itself");

  a_irq_on_ovr: assert property (  // see R19
    rx_interrupt_enable && ovr_q |=> uart_irq)
    else $error("overrun did not raise the interrupt");

  a_trig_four: assert property (  // see R8
    module_enable && rx_trigger_level == TRIG_FOUR &&
    rx_fifo_byte_count != FIFO_FULL |=> !avail_q)
    else $error("available raised below four bytes");

  a_div_low_stage: assert property (  // see R3
    wr && apb.paddr == OFF_DIV_LOW |=> $stable(divisor_q))
    else $error("low byte write changed the divisor");

  a_avail_off: assert property (  // see R20
    !module_enable |=> !avail_q)
    else $error("available flag set while disabled");

  a_ctrl_write: assert property (
    wr && apb.paddr == OFF_CTRL |=>
      ctrl_q == $past(apb.pwdata[CTRL_W-1:0]))
    else $error("control write did not land");

  c_irq_rise: cover property ($rose(uart_irq));
  c_pop_read: cover property (fifo_pop && rx_fifo_byte_count == FIFO_FULL);
  c_bad_addr: cover property (pslverr && access);
endmodule

//--- tb/uart_baud_gen_rx_fifo_tb.sv
`timescale 1ns/1ps
module uart_baud_gen_rx_fifo_tb;
  import ubg_pkg::*;
  logic         core_clk = 1'b0;
  logic         reset_n;
  ubg_apb_req_t apb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         frame_start;
  logic         frame_active;
  logic         rx_byte_valid;
  logic [7:0]   rx_byte;
  logic [7:0]   go_byte;
  logic         go;
  logic         busy;
  logic         bit_tick;
  logic         sample_strobe;
  logic         uart_irq;
  logic [31:0]  r;
  logic         e;
  int           miscompares;
  int           check_count;
  int           cyc;
  int           ticks[$];
  int           strobes[$];
  int           c;
  int           n;

  ubg_uart_baud_rx dut_u (.core_clk(core_clk), .reset_n(reset_n), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .frame_active(frame_active),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .bit_tick(bit_tick),
    .sample_strobe(sample_strobe), .uart_irq(uart_irq));

  ubg_line_model line_u (.core_clk(core_clk), .reset_n(reset_n), .go(go),
    .go_byte(go_byte), .bit_tick(bit_tick), .frame_start(frame_start),
    .frame_active(frame_active), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .busy(busy));

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (frame_active === 1'b1 && line_u.age_q >= 2'h2) begin
      if (bit_tick === 1'b1) ticks.push_back(cyc);
      if (sample_strobe === 1'b1) strobes.push_back(cyc);
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    @(posedge core_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apb.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk_bit(1'b0, 1'b1, "no pready");
    r = prdata;
    e = pslverr;
    apb <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(r, exp, "read");
    chk_bit(e, 1'b0, "slverr");
  endtask

  task automatic send(input logic [7:0] b);
    int k;
    @(posedge core_clk);
    go      <= 1'b1;
    go_byte <= b;
    @(posedge core_clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (busy !== 1'b0 && k < 5000);
    // Count, then flag, then interrupt, one cycle apart
    repeat (3) @(posedge core_clk);
  endtask

  task automatic baud_chk(input int div, input int md, input logic rs);
    int acc;
    int ex;
    int k;
    int s[$];
    acc = 0;
    chk(32'(ticks.size()), 32'hC, "ticks");
    for (k = 0; k < 12 && ticks.size() == 12; k++) begin
      ex = div + int'(((acc % 8) + md) >= 8);
      acc = (acc + md) % 16;
      if (k > 0) begin
        chk(32'(ticks[k] - ticks[k-1]), 32'(ex), "bit len");
        s = strobes.find(x) with (x > ticks[k-1] && x < ticks[k]);
        chk(32'(s.size()), 32'h3, "strobes");
        if (s.size() == 3) begin
          chk(32'(s[1] - s[0]), 32'h1, "gap1");
          chk(32'(s[2] - s[1]), rs ? 32'h2 : 32'h1, "gap2");
        end
      end
    end
    ticks.delete();
    strobes.delete();
  endtask

  initial begin
    reset_n  = 1'b0;
    apb      = '0;
    go       = 1'b0;
    go_byte  = 8'h00;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    rd_chk(OFF_DIV_LOW, 32'h0);
    rd_chk(OFF_DIV_HIGH, 32'h0);
    rd_chk(OFF_FMC, 32'h0);
    rd_chk(OFF_COUNT, 32'h0);
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_STAT, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0);
    chk_bit(e, 1'b1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
    wr(OFF_FMC, 32'hFF);
    rd_chk(OFF_FMC, 32'h3F);
    wr(OFF_COUNT, 32'h7);
    rd_chk(OFF_COUNT, 32'h0);
    $display("test registers done");
    wr(OFF_CTRL, 32'h1);
    // Low byte first, high byte commits the pair
    wr(OFF_DIV_LOW, 32'h11);
    wr(OFF_DIV_HIGH, 32'h0);
    wr(OFF_FMC, 32'h19);
    ticks.delete();
    strobes.delete();
    send(8'h5A);
    baud_chk(17, 3, 1'b0);
    // Range select first, so a divisor of 9 is never live with range 0
    wr(OFF_FMC, 32'h4);
    wr(OFF_DIV_LOW, 32'h9);
    wr(OFF_DIV_HIGH, 32'h0);
    ticks.delete();
    strobes.delete();
    send(8'hC3);
    baud_chk(9, 0, 1'b1);
    $display("test baud done");
    for (c = 0; c < 4; c++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_FMC, 32'(c) | 32'h4);
      wr(OFF_CTRL, 32'h3);
      for (n = 1; n <= 4; n++) begin
        send(8'h30 + 8'(n));
        rd_chk(OFF_COUNT, 32'(n));
        xfer(1'b0, OFF_STAT, 32'h0);
        chk_bit(r[0], 1'(n >= (c == 0 ? 4 : c)), "avail");
        chk_bit(uart_irq, 1'(n >= (c == 0 ? 4 : c)), "irq");
      end
    end
    $display("test trigger done");
    send(8'hE5);
    send(8'hE6);
    rd_chk(OFF_COUNT, 32'h4);
    rd_chk(OFF_STAT, 32'h3);
    rd_chk(OFF_DATA, 32'h31);
    rd_chk(OFF_COUNT, 32'h4);
    rd_chk(OFF_DATA, 32'h32);
    rd_chk(OFF_COUNT, 32'h3);
    rd_chk(OFF_DATA, 32'h33);
    rd_chk(OFF_DATA, 32'h34);
    rd_chk(OFF_DATA, 32'hE6);
    rd_chk(OFF_COUNT, 32'h0);
    rd_chk(OFF_DATA, 32'h0);
    chk_bit(uart_irq, 1'b1, "irq overrun");
    wr(OFF_STAT, 32'h2);
    rd_chk(OFF_STAT, 32'h0);
    chk_bit(uart_irq, 1'b0, "irq idle");
    $display("test overrun done");
    wr(OFF_FMC, 32'h5);
    wr(OFF_CTRL, 32'h1);
    send(8'h77);
    rd_chk(OFF_STAT, 32'h1);
    chk_bit(uart_irq, 1'b0, "irq masked");
    wr(OFF_CTRL, 32'h3);
    repeat (3) @(posedge core_clk);
    chk_bit(uart_irq, 1'b1, "irq unmasked");
    wr(OFF_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    chk_bit(uart_irq, 1'b0, "irq disabled");
    rd_chk(OFF_COUNT, 32'h0);
    rd_chk(OFF_STAT, 32'h0);
    rd_chk(OFF_FMC, 32'h5);
    rd_chk(OFF_DIV_LOW, 32'h9);
    send(8'h66);
    rd_chk(OFF_COUNT, 32'h0);
    $display("test disable done");
    wrap_up();
  end

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule

//--- tb/ubg_line_model.sv
`timescale 1ns/1ps
module ubg_line_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       go,
  input  wire logic [7:0] go_byte,
  input  wire logic       bit_tick,
  output logic            frame_start,
  output logic            frame_active,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  output logic            busy
);
  logic [3:0] bits_q;
  logic [1:0] age_q;
  logic [7:0] byte_q;

  assign busy = frame_active | rx_byte_valid;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_start   <= 1'b0;
      frame_active  <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_byte       <= 8'hA5;
      bits_q        <= 4'h0;
      age_q         <= 2'h0;
      byte_q        <= 8'h00;
    end else begin
      frame_start   <= 1'b0;
      rx_byte_valid <= 1'b0;
      // Data is only meaningful with valid, so it toggles otherwise
      rx_byte       <= ~rx_byte;
      if (go && !busy) begin
        frame_start  <= 1'b1;
        frame_active <= 1'b1;
        bits_q       <= 4'h0;
        age_q        <= 2'h0;
        byte_q       <= go_byte;
      end else if (frame_active) begin
        if (age_q != 2'h3) begin
          age_q <= age_q + 2'h1;
        end
        // Ticks left over from before the start bit are ignored
        if (bit_tick && age_q >= 2'h2) begin
          bits_q <= bits_q + 4'h1;
          // Start, eight data, parity and two stop bits
          if (bits_q == 4'hB) begin
            frame_active  <= 1'b0;
            rx_byte_valid <= 1'b1;
            rx_byte       <= byte_q;
          end
        end
      end
    end
  end
endmodule
